// ===== core/dmt_core.sv
// deadman timer clear keys, status flags and low counter readback
// assumes a single clock, synchronous reset and one-cycle bus strobes
//
// Operation
// - a wrong first clear key write sets the first-key error flag at status bit 7.
// - a wrong second clear key write sets the second-key error flag at status bit 6.
// - counter expiry or a bad key write sets the deadman event flag at status bit 5.
// - status bit 0 shows whether the clear window is open.
// - status bits 15 to 8 and 4 to 1 read zero and ignore writes.
// - the count register returns the low sixteen counter bits and resets to zero.
// - a deadman reset clears both key fields and the error flags.
// - a wrong second key keeps the first key and captures the new second key.
`timescale 1ns/1ps
`default_nettype none
module dmt_core #(
  parameter int ADDR_W = dmt_pkg::ADDR_W,
  parameter int DATA_W = dmt_pkg::DATA_W,
  parameter int KEY_W  = dmt_pkg::KEY_W,
  parameter int CNT_W  = dmt_pkg::CNT_W,
  parameter int IRQ_N  = dmt_pkg::IRQ_N
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              we_i,
  input  wire logic              re_i,
  output logic      [DATA_W-1:0] rdata_o,
  input  wire logic              tick_i,
  input  wire logic              dm_reset_i,
  input  wire logic [CNT_W-1:0]  period_i,
  input  wire logic [CNT_W-1:0]  window_i,
  output logic                   event_o,
  output logic                   irq_o
);

  typedef struct packed {
    logic [KEY_W-1:0]  key1;
    logic [KEY_W-1:0]  key2;
    logic              first_key_error;
    logic              second_key_error;
    logic              event_flag;
    logic              win_q;
    logic [DATA_W-1:0] rdata;
  } dmt_core_state_type;

  dmt_core_state_type s;
  dmt_core_state_type next_s;

  // address decode
  logic key1_we;
  logic key2_we;
  logic ack_we;
  logic mask_we;

  // key checks
  logic [KEY_W-1:0] wkey;
  logic             key1_good;
  logic             key2_good;
  logic             key1_loaded;
  logic             clear_ok;
  logic             first_key_error_set;
  logic             second_key_error_set;

  // counter side
  logic [CNT_W-1:0] count;
  logic             expire;
  logic             window;
  logic             cnt_clr;

  // interrupt side
  logic [IRQ_N-1:0] irq_set;
  logic [IRQ_N-1:0] irq_status;
  logic [IRQ_N-1:0] irq_mask;

  // status word assembled from flags
  logic [DATA_W-1:0] stat_word;

  assign key1_we = we_i && (addr_i == dmt_pkg::OFF_KEY1);
  assign key2_we = we_i && (addr_i == dmt_pkg::OFF_KEY2);
  assign ack_we  = we_i && (addr_i == dmt_pkg::OFF_IRQ_STAT);
  assign mask_we = we_i && (addr_i == dmt_pkg::OFF_IRQ_MASK);

  assign wkey        = wdata_i[KEY_W-1:0];
  assign key1_good   = (wkey == dmt_pkg::KEY1_GOOD);
  assign key2_good   = (wkey == dmt_pkg::KEY2_GOOD);
  assign key1_loaded = (s.key1 == dmt_pkg::KEY1_GOOD);

  // second key only counts after a good first key and inside the window
  assign clear_ok = key2_we && key2_good && key1_loaded && window;

  assign first_key_error_set = key1_we && !key1_good;
  assign second_key_error_set = key2_we && !clear_ok;

  // a good sequence or a deadman reset restarts the count
  assign cnt_clr = clear_ok || dm_reset_i;

  dmt_counter #(
    .CNT_W (CNT_W)
  ) u_counter (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .clr_i    (cnt_clr),
    .tick_i   (tick_i),
    .period_i (period_i),
    .window_i (window_i),
    .count_o  (count),
    .expire_o (expire),
    .window_o (window)
  );

  // status layout, unimplemented bits tied low
  always_comb begin
    stat_word = '0;
    stat_word[dmt_pkg::ST_FIRST_KEY_ERROR]  = s.first_key_error;
    stat_word[dmt_pkg::ST_SECOND_KEY_ERROR]  = s.second_key_error;
    stat_word[dmt_pkg::ST_EVENT] = s.event_flag;
    stat_word[dmt_pkg::ST_WIN]   = window;
  end

  always_comb begin
    next_s = s;
    next_s.win_q = window;

    // deadman reset clears first, so a same-cycle set still lands
    if (dm_reset_i) begin
      next_s.key1       = dmt_pkg::KEY_RST;
      next_s.key2       = dmt_pkg::KEY_RST;
      next_s.first_key_error       = 1'b0;
      next_s.second_key_error       = 1'b0;
      next_s.event_flag = 1'b0;
    end

    if (key1_we) begin
      next_s.key1 = wkey;
      if (!key1_good) begin
        next_s.first_key_error = 1'b1;
      end
    end

    if (key2_we) begin
      if (clear_ok) begin
        // good sequence wipes both key fields
        next_s.key1 = dmt_pkg::KEY_RST;
        next_s.key2 = dmt_pkg::KEY_RST;
      end else begin
        // first key stays as it was
        next_s.key2 = wkey;
        next_s.second_key_error = 1'b1;
      end
    end

    if (expire || first_key_error_set || second_key_error_set) begin
      next_s.event_flag = 1'b1;
    end

    // read data stands one cycle; reads touch nothing else
    next_s.rdata = dmt_pkg::DATA_RST;
    if (re_i) begin
      if (addr_i == dmt_pkg::OFF_KEY1) begin
        next_s.rdata[KEY_W-1:0] = s.key1;
      end else if (addr_i == dmt_pkg::OFF_KEY2) begin
        next_s.rdata[KEY_W-1:0] = s.key2;
      end else if (addr_i == dmt_pkg::OFF_STAT) begin
        next_s.rdata = stat_word;
      end else if (addr_i == dmt_pkg::OFF_CNTL) begin
        next_s.rdata = count[DATA_W-1:0];
      end else if (addr_i == dmt_pkg::OFF_IRQ_STAT) begin
        next_s.rdata[IRQ_N-1:0] = irq_status;
      end else if (addr_i == dmt_pkg::OFF_IRQ_MASK) begin
        next_s.rdata[IRQ_N-1:0] = irq_mask;
      end else begin
        next_s.rdata = dmt_pkg::DATA_RST;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // interrupt events, window one on its rising edge only
  always_comb begin
    irq_set = '0;
    irq_set[dmt_pkg::IRQ_FIRST_KEY_ERROR]  = first_key_error_set;
    irq_set[dmt_pkg::IRQ_SECOND_KEY_ERROR]  = second_key_error_set;
    irq_set[dmt_pkg::IRQ_EVENT] = expire || first_key_error_set || second_key_error_set;
    irq_set[dmt_pkg::IRQ_WIN]   = window && !s.win_q;
  end

  dmt_sticky #(
    .N (IRQ_N)
  ) u_sticky (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .set_i     (irq_set),
    .ack_we_i  (ack_we),
    .mask_we_i (mask_we),
    .wdata_i   (wdata_i[IRQ_N-1:0]),
    .status_o  (irq_status),
    .mask_o    (irq_mask),
    .irq_o     (irq_o)
  );

  assign rdata_o = s.rdata;
  assign event_o = s.event_flag;

endmodule
`default_nettype wire

// ===== include/dmt_pkg.sv
// constants shared by the deadman status and count readback block
// assumes a 16-bit register port and an instruction tick from the core
package dmt_pkg;

  // widths
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int KEY_W  = 8;
  localparam int CNT_W  = 32;
  localparam int IRQ_N  = 4;

  // register offsets, in register index units
  localparam logic [3:0] OFF_KEY1     = 4'h0;
  localparam logic [3:0] OFF_KEY2     = 4'h1;
  localparam logic [3:0] OFF_STAT     = 4'h2;
  localparam logic [3:0] OFF_CNTL     = 4'h3;
  localparam logic [3:0] OFF_IRQ_STAT = 4'h4;
  localparam logic [3:0] OFF_IRQ_MASK = 4'h5;

  // status register field positions
  localparam int ST_FIRST_KEY_ERROR  = 7;
  localparam int ST_SECOND_KEY_ERROR  = 6;
  localparam int ST_EVENT = 5;
  localparam int ST_WIN   = 0;

  // interrupt status and mask field positions
  localparam int IRQ_FIRST_KEY_ERROR  = 0;
  localparam int IRQ_SECOND_KEY_ERROR  = 1;
  localparam int IRQ_EVENT = 2;
  localparam int IRQ_WIN   = 3;

  // clear key values
  localparam logic [7:0] KEY1_GOOD = 8'h40;
  localparam logic [7:0] KEY2_GOOD = 8'h08;

  // reset values
  localparam logic [7:0]  KEY_RST  = 8'h00;
  localparam logic [31:0] CNT_RST  = 32'h0000_0000;
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [3:0]  IRQ_RST  = 4'h0;

endpackage

// ===== core/dmt_counter.sv
// deadman instruction counter with expiry pulse and clear window level
// assumes tick_i is one cycle per counted instruction
`timescale 1ns/1ps
`default_nettype none
module dmt_counter #(
  parameter int CNT_W = dmt_pkg::CNT_W
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             clr_i,
  input  wire logic             tick_i,
  input  wire logic [CNT_W-1:0] period_i,
  input  wire logic [CNT_W-1:0] window_i,
  output logic      [CNT_W-1:0] count_o,
  output logic                  expire_o,
  output logic                  window_o
);

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic             expire;
    logic             window;
  } dmt_cnt_state_type;

  dmt_cnt_state_type s;
  dmt_cnt_state_type next_s;

  always_comb begin
    next_s = s;
    next_s.expire = 1'b0;
    if (clr_i) begin
      next_s.count = dmt_pkg::CNT_RST;
    end else if (tick_i) begin
      // period of zero wraps to the full range
      if (s.count == period_i - 1'b1) begin
        next_s.count  = dmt_pkg::CNT_RST;
        next_s.expire = 1'b1;
      end else begin
        next_s.count = s.count + 1'b1;
      end
    end
    next_s.window = !clr_i && (next_s.count >= window_i);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign count_o  = s.count;
  assign expire_o = s.expire;
  assign window_o = s.window;

endmodule
`default_nettype wire

// ===== core/dmt_sticky.sv
// sticky interrupt status with write-one-to-clear and a mask
// assumes set pulses come from the clock domain of clk_i
`timescale 1ns/1ps
`default_nettype none
module dmt_sticky #(
  parameter int N = dmt_pkg::IRQ_N
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [N-1:0] set_i,
  input  wire logic         ack_we_i,
  input  wire logic         mask_we_i,
  input  wire logic [N-1:0] wdata_i,
  output logic      [N-1:0] status_o,
  output logic      [N-1:0] mask_o,
  output logic              irq_o
);

  typedef struct packed {
    logic [N-1:0] status;
    logic [N-1:0] mask;
  } dmt_irq_state_type;

  dmt_irq_state_type s;
  dmt_irq_state_type next_s;
  logic [N-1:0]      next_status;

  // set wins over a clear in the same cycle
  for (genvar g = 0; g < N; g++) begin : g_bit
    assign next_status[g] = set_i[g] | (s.status[g] & ~(ack_we_i & wdata_i[g]));
  end

  always_comb begin
    next_s = s;
    next_s.status = next_status;
    if (mask_we_i) begin
      next_s.mask = wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign status_o = s.status;
  assign mask_o   = s.mask;
  assign irq_o    = |(s.status & s.mask);

endmodule
`default_nettype wire

// ===== testbench/dmt_core_chk.sv
// port-level checks of the deadman status and count readback block
// assumes registered read data one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
module dmt_core_chk #(
  parameter int ADDR_W = dmt_pkg::ADDR_W,
  parameter int DATA_W = dmt_pkg::DATA_W,
  parameter int CNT_W  = dmt_pkg::CNT_W
) (
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic              we_i,
  input wire logic              re_i,
  input wire logic [DATA_W-1:0] rdata_o,
  input wire logic              tick_i,
  input wire logic              dm_reset_i,
  input wire logic [CNT_W-1:0]  window_i,
  input wire logic              event_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_rd_idle; !$past(re_i) |-> rdata_o == 16'h0000; endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside a read slot");
  property p_stat_zero; re_i && addr_i == dmt_pkg::OFF_STAT
    |=> rdata_o[15:8] == 8'h00 && rdata_o[4:1] == 4'h0; endproperty
  a_stat_zero: assert property (p_stat_zero)
    else $error("status reserved bits not zero");
  property p_evt_mirror; re_i && addr_i == dmt_pkg::OFF_STAT
    |=> rdata_o[5] == $past(event_o); endproperty
  a_evt_mirror: assert property (p_evt_mirror)
    else $error("status event bit differs from event output");
  property p_first_key_error; (we_i && addr_i == dmt_pkg::OFF_KEY1 && wdata_i[7:0] != dmt_pkg::KEY1_GOOD)
    ##1 (re_i && addr_i == dmt_pkg::OFF_STAT) |=> rdata_o[7] && rdata_o[5]; endproperty
  a_first_key_error: assert property (p_first_key_error)
    else $error("bad first key not flagged");
  property p_second_key_error; (we_i && addr_i == dmt_pkg::OFF_KEY2 && wdata_i[7:0] != dmt_pkg::KEY2_GOOD)
    ##1 (re_i && addr_i == dmt_pkg::OFF_STAT) |=> rdata_o[6] && rdata_o[5]; endproperty
  a_second_key_error: assert property (p_second_key_error)
    else $error("bad second key not flagged");
  property p_evt_hold; event_o && !dm_reset_i |=> event_o; endproperty
  a_evt_hold: assert property (p_evt_hold)
    else $error("event flag dropped without deadman reset");
  property p_evt_clear; dm_reset_i && !we_i && !$past(tick_i) && !$past(tick_i, 2)
    |=> !event_o; endproperty
  a_evt_clear: assert property (p_evt_clear)
    else $error("event flag survived deadman reset");
  property p_cnt_stable; (re_i && addr_i == dmt_pkg::OFF_CNTL && !tick_i && !dm_reset_i)
    ##1 (re_i && addr_i == dmt_pkg::OFF_CNTL) |=> rdata_o == $past(rdata_o); endproperty
  a_cnt_stable: assert property (p_cnt_stable)
    else $error("count moved without a tick");
  property p_win_clear; dm_reset_i && !tick_i && window_i > 32'h0000_0001
    ##1 (re_i && addr_i == dmt_pkg::OFF_STAT) |=> !rdata_o[0]; endproperty
  a_win_clear: assert property (p_win_clear)
    else $error("window open after deadman reset");
endmodule
bind dmt_core dmt_core_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .CNT_W(CNT_W)) chk (
  .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i),
  .re_i(re_i), .rdata_o(rdata_o), .tick_i(tick_i), .dm_reset_i(dm_reset_i),
  .window_i(window_i), .event_o(event_o));
`default_nettype wire

// ===== testbench/dmt_core_test.sv
// self-checking bench for the deadman status and count readback block
// assumes period 8 and window 4 held on the count inputs
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
  $display("FAIL %s expected %h seen %h", nm, e, g); end end
module dmt_core_test;
  logic        clk_i = 0, rst_i = 1, we_i = 0, re_i = 0, tick_i = 0, dm_reset_i = 0, re_q = 0;
  logic [3:0]  addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000, rdata_o, v, e;
  logic        event_o, irq_o;
  logic [31:0] seed = 32'h1ce9;
  logic [15:0] q[$];
  int          mismatches = 0, n_compared = 0;
  dmt_core DUT (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .tick_i(tick_i), .dm_reset_i(dm_reset_i),
    .period_i(32'h0000_0008), .window_i(32'h0000_0004), .event_o(event_o), .irq_o(irq_o));
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  // one bus cycle per call, so back-to-back strobes never assign twice in a step
  task automatic bus(logic w, logic r, logic [3:0] a, logic [15:0] d);
    we_i <= w; re_i <= r; addr_i <= a; wdata_i <= d;
    @(posedge clk_i);
  endtask
  task automatic rd(logic [3:0] a, logic [15:0] x);
    q.push_back(x);
    bus(0, 1, a, 16'h0000);
  endtask
  task automatic idle(int n);
    repeat (n) bus(0, 0, 4'h0, 16'h0000);
  endtask
  // strobes drop with the pulse, else a pending read is taken twice
  task automatic tk(int n);
    repeat (n) begin
      tick_i <= 1;
      bus(0, 0, 4'h0, 16'h0000);
    end
    tick_i <= 0;
    idle(2);
  endtask
  task automatic dmr();
    dm_reset_i <= 1;
    bus(0, 0, 4'h0, 16'h0000);
    dm_reset_i <= 0;
    idle(2);
  endtask
  function automatic logic [31:0] lfsr(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // random wrong key, never the good value
  task automatic bad(logic [7:0] good);
    seed = lfsr(seed);
    v = {8'h00, seed[7:0]};
    if (v[7:0] == good) v[0] = ~v[0];
  endtask
  task automatic tdone(string s);
    idle(3); $display("test %s done", s);
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // read data stand for the one cycle after the strobe; sampled mid-cycle
  always @(posedge clk_i) re_q <= re_i;
  always @(negedge clk_i) begin
    if (re_q) begin
      e = (q.size() > 0) ? q.pop_front() : 16'hxxxx;
      `CHK("rdata", e, rdata_o)
    end
  end
  initial begin
    repeat (3000) @(posedge clk_i);
    mismatches++;
    results();
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 0;
    rd(dmt_pkg::OFF_STAT, 16'h0000);
    rd(dmt_pkg::OFF_CNTL, 16'h0000);
    tdone("reset");
    tk(3);
    rd(dmt_pkg::OFF_STAT, 16'h0000);
    rd(dmt_pkg::OFF_CNTL, 16'h0003);
    rd(dmt_pkg::OFF_CNTL, 16'h0003);
    tk(1);
    rd(dmt_pkg::OFF_STAT, 16'h0001);
    tk(4);
    rd(dmt_pkg::OFF_CNTL, 16'h0000);
    rd(dmt_pkg::OFF_STAT, 16'h0020);
    `CHK("event", 1'b1, event_o)
    bus(1, 0, dmt_pkg::OFF_STAT, 16'hffff);
    bus(1, 0, dmt_pkg::OFF_CNTL, 16'hffff);
    rd(dmt_pkg::OFF_STAT, 16'h0020);
    rd(dmt_pkg::OFF_CNTL, 16'h0000);
    rd(4'hf, 16'h0000);
    tdone("count");
    rd(dmt_pkg::OFF_IRQ_STAT, 16'h000c);
    bus(1, 0, dmt_pkg::OFF_IRQ_MASK, 16'h0004);
    idle(2);
    `CHK("irq", 1'b1, irq_o)
    bus(1, 0, dmt_pkg::OFF_IRQ_STAT, 16'h0004);
    idle(2);
    `CHK("irq", 1'b0, irq_o)
    rd(dmt_pkg::OFF_IRQ_STAT, 16'h0008);
    tdone("irq");
    dmr();
    rd(dmt_pkg::OFF_STAT, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      bad(dmt_pkg::KEY1_GOOD);
      bus(1, 0, dmt_pkg::OFF_KEY1, v);
      rd(dmt_pkg::OFF_STAT, 16'h00a0);
      rd(dmt_pkg::OFF_KEY1, v);
      dmr();
    end
    tdone("key1");
    bad(dmt_pkg::KEY2_GOOD);
    bus(1, 0, dmt_pkg::OFF_KEY1, 16'h0040);
    bus(1, 0, dmt_pkg::OFF_KEY2, v);
    rd(dmt_pkg::OFF_STAT, 16'h0060);
    rd(dmt_pkg::OFF_KEY1, 16'h0040);
    rd(dmt_pkg::OFF_KEY2, v);
    dmr();
    rd(dmt_pkg::OFF_KEY1, 16'h0000);
    rd(dmt_pkg::OFF_KEY2, 16'h0000);
    rd(dmt_pkg::OFF_STAT, 16'h0000);
    tdone("key2");
    tk(5);
    bus(1, 0, dmt_pkg::OFF_KEY1, 16'h0040);
    bus(1, 0, dmt_pkg::OFF_KEY2, 16'h0008);
    idle(1);
    rd(dmt_pkg::OFF_CNTL, 16'h0000);
    rd(dmt_pkg::OFF_STAT, 16'h0000);
    tk(5);
    // deadman reset with the window open, status read right behind it
    dm_reset_i <= 1;
    bus(0, 0, 4'h0, 16'h0000);
    dm_reset_i <= 0;
    rd(dmt_pkg::OFF_STAT, 16'h0000);
    rd(dmt_pkg::OFF_CNTL, 16'h0000);
    tdone("clear");
    results();
  end
endmodule
`default_nettype wire
